// ### rtl/ssc_pkg.sv
// System clock source select: shared constants, types and register map.
// Assumes one 20 MHz system clock and a plain address/strobe register port.
`default_nettype none
package ssc_pkg;

    localparam int CLK_NS = 50;

    // Default source configuration codes
    localparam logic [2:0] CFG_LP  = 3'h0;
    localparam logic [2:0] CFG_XT  = 3'h1;
    localparam logic [2:0] CFG_HS  = 3'h2;
    localparam logic [2:0] CFG_RC  = 3'h3;
    localparam logic [2:0] CFG_INT = 3'h4;
    localparam logic [2:0] CFG_ECL = 3'h5;
    localparam logic [2:0] CFG_ECM = 3'h6;
    localparam logic [2:0] CFG_ECH = 3'h7;

    localparam int OST_COUNT = 1024;

    // Oscillator settling, least times, rounded up to whole cycles
    localparam int FAST_RUN_NS    = 2000;
    localparam int FAST_STABLE_NS = 10000;
    localparam int SLOW_RUN_NS    = 1000;
    localparam int FAST_RUN_CYC    = (FAST_RUN_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAST_STABLE_CYC = (FAST_STABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOW_RUN_CYC    = (SLOW_RUN_NS + CLK_NS - 1) / CLK_NS;

    // Register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam int CTRL_SCS_LSB   = 0;
    localparam int CTRL_FREQ_LSB  = 3;
    localparam int STAT_FAST_STB  = 0;
    localparam int STAT_SLOW_RUN  = 1;
    localparam int STAT_FAST_RUN  = 4;
    localparam int STAT_OST_DONE  = 5;
    localparam logic [1:0] SCS_RST  = 2'h0;
    localparam logic [3:0] FREQ_RST = 4'h7;
    localparam logic [3:0] FREQ_LF  = 4'h0;
    localparam logic [1:0] SCS_SEC  = 2'h1;

    typedef enum logic [2:0] {
        SRC_EXT  = 3'h0,
        SRC_XTAL = 3'h1,
        SRC_RC   = 3'h2,
        SRC_SEC  = 3'h3,
        SRC_POST = 3'h4,
        SRC_SLOW = 3'h5,
        SRC_BOOT = 3'h6
    } ssc_src_t;

    typedef enum logic [1:0] {
        OST_IDLE = 2'h0,
        OST_POWER_UP_TIMER = 2'h1,
        OST_RUN  = 2'h2,
        OST_DONE = 2'h3
    } ssc_ost_t;

    typedef enum logic [1:0] {
        GAIN_OFF  = 2'h0,
        GAIN_LOW  = 2'h1,
        GAIN_MED  = 2'h2,
        GAIN_HIGH = 2'h3
    } ssc_gain_t;

    typedef struct packed {
        logic [2:0] default_source_config;
        logic       clock_output_pin_enable;
        logic       failsafe_en;
        logic       two_speed_en;
        logic       power_up_timer_en;
        logic       wdt_en;
    } ssc_cfg_t;

    typedef struct packed {
        logic primary_gpio;
        logic sec_clkout;
        logic sec_gpio;
    } ssc_pins_t;

endpackage
`default_nettype wire

// ### rtl/ssc_top.sv
// System clock source selection, crystal start-up timer and oscillator status.
// Assumes config words held stable, por/wake/power_up_timer pulses from same clock,
// and the primary oscillator pin arriving asynchronously.
//
// Overview of operation
// - External clock ranges use configuration codes 111, 110 and 101.
// - External clock mode never runs the start-up timer; no delay.
// - Logic is static; a stopped clock holds all state intact.
// - Crystal modes count 1024 primary edges before using the oscillator.
// - Count starts after power-on (after power-up timer) and each wake.
// - During the count with select 00 the processor is held, unless monitor or two-speed.
// - With monitor or two-speed, execution runs on internal clock meanwhile.
// - Crystal modes select low, medium or high amplifier gain.
// - In RC and internal modes a bit picks clock output or I/O.
// - Internal oscillator configuration frees the primary pin for I/O.
// - Fast oscillator on for high frequency with config 100 or select 1x.
// - Fast oscillator passes a postscaler chosen by frequency select.
// - A status bit shows the fast oscillator running.
// - A status bit shows the fast oscillator settled within 0.5%.
// - A start-up oscillator clocks logic until the fast one runs.
// - Slow oscillator on for frequency 0000 with select 1x or users.
// - Slow oscillator also clocks power-up timer, watchdog and monitor.
// - A status bit shows the slow oscillator running.
// - After reset the configured default source is the system clock.
// - Secondary timekeeping oscillator selectable at run time.
// - Select 00 default, 01 secondary, 1x internal block.
// - Reset loads frequency select with 0111, meaning 500 kHz.
// - Reset clears the source select field.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssc_top #(
    parameter int OST_CYCLES = ssc_pkg::OST_COUNT
) (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire ssc_pkg::ssc_cfg_t cfg_in,
    input  wire logic              por_in,
    input  wire logic              wake_in,
    input  wire logic              power_up_timer_done_in,
    input  wire logic              primary_osc_in,
    input  wire logic [3:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [7:0]             reg_rdata_out,
    output ssc_pkg::ssc_src_t      sys_src_out,
    output logic [3:0]             post_div_out,
    output logic                   cpu_hold_out,
    output ssc_pkg::ssc_gain_t     amp_gain_out,
    output ssc_pkg::ssc_pins_t     pins_out,
    output logic                   fast_osc_en_out,
    output logic                   slow_osc_en_out
);

    // The start-up counter is 11 bits wide, so larger counts cannot be served
    if (OST_CYCLES < 1 || OST_CYCLES > 2047) begin : g_bad_ost
        $error("OST_CYCLES out of range");
    end

    // log2 of the postscaler divide for each high-frequency select code
    function automatic logic [3:0] post_div(input logic [3:0] f);
        logic [3:0] d;
        d = 4'h0;
        if (f[3])
            d = 4'hf - f;
        else if (f >= 4'h4)
            d = 4'hc - f;
        else if (f != 4'h0)
            d = 4'h9;
        return d;
    endfunction

    logic [2:0] cfg;
    logic       xtal;
    logic       ec;
    logic       bypass;
    assign cfg    = cfg_in.default_source_config;
    assign xtal   = (cfg == ssc_pkg::CFG_LP) || (cfg == ssc_pkg::CFG_XT)
                    || (cfg == ssc_pkg::CFG_HS);
    assign ec     = (cfg == ssc_pkg::CFG_ECL) || (cfg == ssc_pkg::CFG_ECM)
                    || (cfg == ssc_pkg::CFG_ECH);
    assign bypass = cfg_in.failsafe_en || cfg_in.two_speed_en;

    // Control register
    logic [1:0] scs;
    logic [3:0] freq;
    logic [1:0] next_scs;
    logic [3:0] next_freq;

    always_comb begin
        next_scs  = scs;
        next_freq = freq;
        if (reg_wr_in && reg_addr_in == ssc_pkg::ADDR_CTRL) begin
            next_scs  = reg_wdata_in[ssc_pkg::CTRL_SCS_LSB +: 2];
            next_freq = reg_wdata_in[ssc_pkg::CTRL_FREQ_LSB +: 4];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            scs  <= ssc_pkg::SCS_RST;
            freq <= ssc_pkg::FREQ_RST;
        end else begin
            scs  <= next_scs;
            freq <= next_freq;
        end
    end

    // Primary pin synchroniser: a change counts once stages two and three agree
    logic       prim_s1;
    logic       prim_s2;
    logic       prim_s3;
    logic       prim_lvl;
    logic       next_prim_lvl;
    logic       prim_edge;

    always_comb begin
        next_prim_lvl = (prim_s2 == prim_s3) ? prim_s3 : prim_lvl;
    end
    assign prim_edge = next_prim_lvl && !prim_lvl;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prim_s1  <= 1'b0;
            prim_s2  <= 1'b0;
            prim_s3  <= 1'b0;
            prim_lvl <= 1'b0;
        end else begin
            prim_s1  <= primary_osc_in;
            prim_s2  <= prim_s1;
            prim_s3  <= prim_s2;
            prim_lvl <= next_prim_lvl;
        end
    end

    // Crystal start-up timer; counts pin edges only, no timeout, so a
    // stalled clock simply freezes it where it stands
    ssc_pkg::ssc_ost_t ost_q;
    ssc_pkg::ssc_ost_t next_ost;
    logic [10:0]       ost_cnt;
    logic [10:0]       next_ost_cnt;

    always_comb begin
        next_ost     = ost_q;
        next_ost_cnt = ost_cnt;
        unique case (ost_q)
            ssc_pkg::OST_IDLE, ssc_pkg::OST_DONE: begin
                if (por_in && xtal) begin
                    next_ost_cnt = 11'h0;
                    next_ost     = cfg_in.power_up_timer_en ? ssc_pkg::OST_POWER_UP_TIMER
                                                  : ssc_pkg::OST_RUN;
                end else if (wake_in && xtal) begin
                    next_ost_cnt = 11'h0;
                    next_ost     = ssc_pkg::OST_RUN;
                end else if ((por_in || wake_in) && !xtal) begin
                    next_ost = ssc_pkg::OST_DONE;
                end
            end
            ssc_pkg::OST_POWER_UP_TIMER: begin
                if (power_up_timer_done_in)
                    next_ost = ssc_pkg::OST_RUN;
            end
            ssc_pkg::OST_RUN: begin
                if (!xtal) begin
                    next_ost = ssc_pkg::OST_DONE;
                end else if (prim_edge) begin
                    next_ost_cnt = ost_cnt + 11'h1;
                    if (ost_cnt == 11'(OST_CYCLES - 1))
                        next_ost = ssc_pkg::OST_DONE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ost_q   <= ssc_pkg::OST_IDLE;
            ost_cnt <= 11'h0;
        end else begin
            ost_q   <= next_ost;
            ost_cnt <= next_ost_cnt;
        end
    end

    logic ost_busy;
    assign ost_busy = xtal && (ost_q == ssc_pkg::OST_POWER_UP_TIMER || ost_q == ssc_pkg::OST_RUN);

    // Oscillator enables
    logic int_sel;
    assign int_sel = scs[1] || (scs == ssc_pkg::SCS_RST && cfg == ssc_pkg::CFG_INT);

    always_comb begin
        fast_osc_en_out = ((freq != ssc_pkg::FREQ_LF)
                          && (cfg == ssc_pkg::CFG_INT || scs[1]))
                          || (ost_busy && bypass && scs == ssc_pkg::SCS_RST);
        slow_osc_en_out = ((freq == ssc_pkg::FREQ_LF) && int_sel)
                          || cfg_in.wdt_en || cfg_in.failsafe_en
                          || ost_q == ssc_pkg::OST_POWER_UP_TIMER;
    end

    // Settling counters model oscillator start-up; they restart when disabled
    logic [9:0] fast_cnt;
    logic [9:0] slow_cnt;
    logic [9:0] next_fast_cnt;
    logic [9:0] next_slow_cnt;
    logic       fast_run;
    logic       fast_stable;
    logic       slow_run;

    always_comb begin
        next_fast_cnt = 10'h0;
        next_slow_cnt = 10'h0;
        if (fast_osc_en_out)
            next_fast_cnt = fast_stable ? fast_cnt : fast_cnt + 10'h1;
        if (slow_osc_en_out)
            next_slow_cnt = slow_run ? slow_cnt : slow_cnt + 10'h1;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            fast_cnt <= 10'h0;
            slow_cnt <= 10'h0;
        end else begin
            fast_cnt <= next_fast_cnt;
            slow_cnt <= next_slow_cnt;
        end
    end

    assign fast_run    = fast_cnt >= 10'(ssc_pkg::FAST_RUN_CYC);
    assign fast_stable = fast_cnt >= 10'(ssc_pkg::FAST_STABLE_CYC);
    assign slow_run    = slow_cnt >= 10'(ssc_pkg::SLOW_RUN_CYC);

    // Source multiplexer
    ssc_pkg::ssc_src_t int_src;
    always_comb begin
        if (freq == ssc_pkg::FREQ_LF)
            int_src = ssc_pkg::SRC_SLOW;
        else if (fast_run)
            int_src = ssc_pkg::SRC_POST;
        else
            int_src = ssc_pkg::SRC_BOOT;
    end

    always_comb begin
        if (scs == ssc_pkg::SCS_SEC)
            sys_src_out = ssc_pkg::SRC_SEC;
        else if (scs[1])
            sys_src_out = int_src;
        else if (cfg == ssc_pkg::CFG_INT)
            sys_src_out = int_src;
        else if (cfg == ssc_pkg::CFG_RC)
            sys_src_out = ssc_pkg::SRC_RC;
        else if (ec)
            sys_src_out = ssc_pkg::SRC_EXT;
        else if (ost_busy && bypass)
            sys_src_out = int_src;
        else
            sys_src_out = ssc_pkg::SRC_XTAL;
    end

    // Outputs steered by configuration
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    always_comb begin
        post_div_out = post_div(freq);
        cpu_hold_out = ost_busy && !bypass && scs == ssc_pkg::SCS_RST;
        unique case (cfg)
            ssc_pkg::CFG_LP: amp_gain_out = ssc_pkg::GAIN_LOW;
            ssc_pkg::CFG_XT: amp_gain_out = ssc_pkg::GAIN_MED;
            ssc_pkg::CFG_HS: amp_gain_out = ssc_pkg::GAIN_HIGH;
            default:         amp_gain_out = ssc_pkg::GAIN_OFF;
        endcase
        pins_out.primary_gpio = cfg == ssc_pkg::CFG_INT;
        pins_out.sec_clkout   = !xtal && cfg_in.clock_output_pin_enable;
        pins_out.sec_gpio     = !xtal && !cfg_in.clock_output_pin_enable;
    end

    // Register read path; status has no write path at all
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_in && reg_addr_in == ssc_pkg::ADDR_CTRL) begin
            next_rdata[ssc_pkg::CTRL_SCS_LSB +: 2]  = scs;
            next_rdata[ssc_pkg::CTRL_FREQ_LSB +: 4] = freq;
        end else if (reg_rd_in && reg_addr_in == ssc_pkg::ADDR_STAT) begin
            next_rdata[ssc_pkg::STAT_FAST_STB] = fast_stable;
            next_rdata[ssc_pkg::STAT_SLOW_RUN] = slow_run;
            next_rdata[ssc_pkg::STAT_FAST_RUN] = fast_run;
            next_rdata[ssc_pkg::STAT_OST_DONE] = ost_q == ssc_pkg::OST_DONE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in)
            rdata <= 8'h00;
        else
            rdata <= next_rdata;
    end
    assign reg_rdata_out = rdata;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_ost_final_edge: assert property (
        ost_q == ssc_pkg::OST_RUN && xtal && prim_edge
        && ost_cnt == 11'(OST_CYCLES - 1) |=> ost_q == ssc_pkg::OST_DONE)
        else $error("start-up count did not finish");
    a_ost_early_done: assert property (
        $rose(ost_q == ssc_pkg::OST_DONE) && xtal |-> $past(ost_cnt) == 11'(OST_CYCLES - 1))
        else $error("start-up count finished early");
    a_ec_no_hold: assert property (
        ec |-> !cpu_hold_out && ost_q != ssc_pkg::OST_RUN)
        else $error("external clock mode delayed");
    a_hold_during_count: assert property (
        xtal && !bypass && scs == ssc_pkg::SCS_RST && ost_q == ssc_pkg::OST_RUN
        |-> cpu_hold_out && sys_src_out == ssc_pkg::SRC_XTAL)
        else $error("processor not held during count");
    a_bypass_internal: assert property (
        ost_busy && bypass |-> !cpu_hold_out && sys_src_out != ssc_pkg::SRC_XTAL)
        else $error("no internal clock during count");
    a_wake_restart: assert property (
        wake_in && !por_in && xtal && ost_q == ssc_pkg::OST_DONE
        |=> ost_q == ssc_pkg::OST_RUN && ost_cnt == 11'h0)
        else $error("wake did not restart count");
    a_gain_select: assert property (
        cfg == ssc_pkg::CFG_LP |-> amp_gain_out == ssc_pkg::GAIN_LOW)
        else $error("low gain not chosen");
    a_fast_enable: assert property (
        freq != ssc_pkg::FREQ_LF && scs[1] |-> fast_osc_en_out)
        else $error("fast oscillator not enabled");
    a_slow_enable: assert property (
        freq == ssc_pkg::FREQ_LF && scs[1] |-> slow_osc_en_out)
        else $error("slow oscillator not enabled");
    a_fast_settle: assert property (
        $rose(fast_osc_en_out) |-> !fast_run [*8])
        else $error("fast oscillator flags set too soon");
    a_stable_needs_run: assert property (
        fast_stable |-> fast_run)
        else $error("fast oscillator stable before running");
    a_slow_users: assert property (
        cfg_in.wdt_en || cfg_in.failsafe_en || ost_q == ssc_pkg::OST_POWER_UP_TIMER |-> slow_osc_en_out)
        else $error("slow oscillator users not served");
    a_secondary_sel: assert property (
        scs == ssc_pkg::SCS_SEC |-> sys_src_out == ssc_pkg::SRC_SEC)
        else $error("secondary source not selected");
    a_reset_values: assert property (
        $past(rst_in) |-> scs == ssc_pkg::SCS_RST && freq == ssc_pkg::FREQ_RST)
        else $error("control not reset");

endmodule // ssc_top
`default_nettype wire

// ### test/ssc_xtal_model.sv
// Crystal or resonator model driving the primary oscillator pin.
// Assumes the bench starts and stops it; the pin rests low while stopped.
`timescale 1ns/1ps
`default_nettype none
module ssc_xtal_model #(
    parameter int HALF_NS = 175
) (
    input  wire logic run_in,
    output var logic  osc_out
);
    // Each full period is one oscillation seen by the start-up count
    initial begin
        osc_out = 1'b0;
        forever begin
            if (run_in) begin
                #HALF_NS osc_out = 1'b1;
                #HALF_NS osc_out = 1'b0;
            end else begin
                @(run_in);
            end
        end
    end
endmodule // ssc_xtal_model
`default_nettype wire

// ### test/system_clock_source_select_test.sv
// Self-checking bench for the clock source select block.
// Assumes OST_CYCLES is cut to 4 and the crystal model feeds the pin.
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_test;
    localparam int OSTN = 4;
    logic clock_in, rst_in, por, wake, pdone, posc, run, wr, rd;
    logic [3:0] addr, pdiv;
    logic [7:0] wdata, rdata, d, pexp;
    logic hold, fen, sen;
    ssc_pkg::ssc_cfg_t cfg;
    ssc_pkg::ssc_src_t src;
    ssc_pkg::ssc_gain_t gain;
    ssc_pkg::ssc_pins_t pins;
    int n_errors = 0;
    int n_compared = 0;

    ssc_top #(.OST_CYCLES(OSTN)) dut_u (
        .clock_in(clock_in), .rst_in(rst_in), .cfg_in(cfg), .por_in(por),
        .wake_in(wake), .power_up_timer_done_in(pdone), .primary_osc_in(posc),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .sys_src_out(src), .post_div_out(pdiv),
        .cpu_hold_out(hold), .amp_gain_out(gain), .pins_out(pins),
        .fast_osc_en_out(fen), .slow_osc_en_out(sen));
    ssc_xtal_model xtal_u (.run_in(run), .osc_out(posc));

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock_in);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rst_with(input ssc_pkg::ssc_cfg_t c);
        @(posedge clock_in);
        rst_in <= 1'b1;
        cfg <= c;
        pdone <= 1'b0;
        cyc(5);
        @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
    endtask

    task automatic ev(input bit is_wake);
        @(posedge clock_in);
        if (is_wake) wake <= 1'b1;
        else por <= 1'b1;
        @(posedge clock_in);
        wake <= 1'b0;
        por <= 1'b0;
        #1;
    endtask

    // Start-up count only advances on real oscillations, so run whole periods;
    // run drops while the pin is high so that no extra period can start
    task automatic osc(input int n);
        run = 1'b1;
        repeat (n) @(posedge posc);
        run = 1'b0;
        @(negedge posc);
        cyc(10);
    endtask

    initial begin
        rst_in = 1'b1;
        cfg = '0;
        por = 1'b0;
        wake = 1'b0;
        pdone = 1'b0;
        run = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        pexp = 8'h00;
        for (int i = 0; i < 8; i++) begin
            rst_with({i[2:0], i[0], 4'h0});
            chk("gain", 8'(gain), (i < 3) ? 8'(i + 1) : 8'h00);
            pexp = {5'h00, i == 4, i >= 3 && i[0], i >= 3 && !i[0]};
            chk("pins", 8'(pins), pexp);
            if (i == 4) chk("boot", 8'(src), 8'(ssc_pkg::SRC_BOOT));
            cyc(50);
            if (i >= 5) chk("ext", 8'(src), 8'(ssc_pkg::SRC_EXT));
            if (i == 3) chk("rc", 8'(src), 8'(ssc_pkg::SRC_RC));
            if (i == 4) chk("int", 8'(src), 8'(ssc_pkg::SRC_POST));
        end
        $display("test config table done");

        rst_with({ssc_pkg::CFG_ECH, 5'h00});
        ev(1'b0);
        chk("ec hold", 8'(hold), 8'h00);
        chk("ec src", 8'(src), 8'(ssc_pkg::SRC_EXT));
        rd_reg(ssc_pkg::ADDR_STAT, d);
        chk("ec done", d & 8'h20, 8'h20);
        $display("test external clock done");

        rst_with({ssc_pkg::CFG_XT, 5'h00});
        for (int w = 0; w < 2; w++) begin
            ev(w[0]);
            chk("ost hold", 8'(hold), 8'h01);
            osc(OSTN - 1);
            chk("ost early", 8'(hold), 8'h01);
            osc(1);
            chk("ost end", 8'(hold), 8'h00);
            chk("ost src", 8'(src), 8'(ssc_pkg::SRC_XTAL));
            rd_reg(ssc_pkg::ADDR_STAT, d);
            chk("ost done", d & 8'h20, 8'h20);
        end
        rst_with({ssc_pkg::CFG_XT, 3'h0, 1'b1, 1'b0});
        ev(1'b0);
        osc(2 * OSTN);
        chk("power_up_timer wait", 8'(hold), 8'h01);
        chk("power_up_timer slow", 8'(sen), 8'h01);
        @(posedge clock_in);
        pdone <= 1'b1;
        osc(OSTN);
        chk("power_up_timer end", 8'(hold), 8'h00);
        rst_with({ssc_pkg::CFG_HS, 2'h0, 1'b1, 2'h0});
        ev(1'b1);
        chk("two speed hold", 8'(hold), 8'h00);
        chk("two speed fast", 8'(fen), 8'h01);
        cyc(50);
        chk("two speed src", 8'(src), 8'(ssc_pkg::SRC_POST));
        rst_with({ssc_pkg::CFG_LP, 1'b0, 1'b1, 3'h0});
        ev(1'b0);
        chk("failsafe hold", 8'(hold), 8'h00);
        chk("failsafe boot", 8'(src), 8'(ssc_pkg::SRC_BOOT));
        chk("failsafe slow", 8'(sen), 8'h01);
        osc(OSTN);
        chk("failsafe src", 8'(src), 8'(ssc_pkg::SRC_XTAL));
        $display("test start-up timer done");

        rst_with({ssc_pkg::CFG_ECH, 5'h00});
        rd_reg(ssc_pkg::ADDR_CTRL, d);
        chk("ctrl reset", d, 8'h38);
        wr_reg(ssc_pkg::ADDR_CTRL, 8'h39);
        chk("sec src", 8'(src), 8'(ssc_pkg::SRC_SEC));
        wr_reg(ssc_pkg::ADDR_CTRL, 8'h02);
        chk("slow src", 8'(src), 8'(ssc_pkg::SRC_SLOW));
        chk("slow en", 8'(sen), 8'h01);
        cyc(25);
        rd_reg(ssc_pkg::ADDR_STAT, d);
        chk("slow run", d & 8'h02, 8'h02);
        wr_reg(ssc_pkg::ADDR_CTRL, 8'h3b);
        chk("fast en", 8'(fen), 8'h01);
        chk("div 0111", 8'(pdiv), 8'h05);
        cyc(210);
        chk("fast src", 8'(src), 8'(ssc_pkg::SRC_POST));
        rd_reg(ssc_pkg::ADDR_STAT, d);
        chk("fast flags", d & 8'h11, 8'h11);
        wr_reg(ssc_pkg::ADDR_STAT, 8'h00);
        rd_reg(ssc_pkg::ADDR_STAT, d);
        chk("stat ro", d & 8'h11, 8'h11);
        wr_reg(ssc_pkg::ADDR_CTRL, 8'h7a);
        chk("div 1111", 8'(pdiv), 8'h00);
        wr_reg(ssc_pkg::ADDR_CTRL, 8'h42);
        chk("div 1000", 8'(pdiv), 8'h07);
        rd_reg(4'hf, d);
        chk("unmapped", d, 8'h00);
        rst_with({ssc_pkg::CFG_ECH, 5'h00});
        rd_reg(ssc_pkg::ADDR_CTRL, d);
        chk("ctrl rereset", d, 8'h38);
        chk("rereset src", 8'(src), 8'(ssc_pkg::SRC_EXT));
        wr_reg(ssc_pkg::ADDR_CTRL, 8'h39);
        cyc(100);
        rd_reg(ssc_pkg::ADDR_CTRL, d);
        chk("static hold", d, 8'h39);
        $display("test source select done");
        summarize();
    end

    // Whole run needs well under a millisecond
    initial begin
        #2000000;
        n_errors++;
        summarize();
    end
endmodule // system_clock_source_select_test
`default_nettype wire
